// ### rtl/cbnv_defines.svh
// Constants of the cell-balance and configuration store block
`ifndef CBNV_DEFINES_SVH
`define CBNV_DEFINES_SVH

`define CBNV_I2C_ADDR 7'h10
`define CBNV_REG_BAL_CFG 8'h0A
`define CBNV_REG_KEY 8'h0B
`define CBNV_KEY_RESET 8'h00
`define CBNV_KEY_PROGRAM 8'h41
`define CBNV_KEY_PREREAD 8'h62
`define CBNV_NV_LAST 4'hA
`define CBNV_EN_OFF 2'b00
`define CBNV_EN_ALWAYS 2'b01
`define CBNV_EN_CHARGER 2'b10
`define CBNV_EN_CHARGER_TIMED 2'b11
`define CBNV_EN_LSB 6
`define CBNV_TO_LSB 4
`define CBNV_TH_LSB 0
`define CBNV_CLK_HZ 200000000
`define CBNV_HOUR_S 3600
`define CBNV_LOAD_MS 125
`define CBNV_PERIOD_S 4

`endif

// ### rtl/cbnv_pkg.sv
// Types shared by the cell-balance and configuration store block
`default_nettype none
package cbnv_pkg;
	typedef enum logic [1:0] {BAL_IDLE, BAL_RUN, BAL_DONE} cbnv_bal_state_t;
	typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_WRITE, I2C_READ} cbnv_i2c_state_t;
	typedef enum logic [1:0] {NV_SCAN, NV_LOAD, NV_COMMIT} cbnv_nv_mode_t;
endpackage : cbnv_pkg
`default_nettype wire

// ### rtl/cbnv_nvm_store.sv
// Non-volatile configuration array with registered read port
`default_nettype none
module cbnv_nvm_store (
	input wire logic clk,
	input wire logic reset,
	input wire logic writeEnable,
	input wire logic [3:0] writeAddr,
	input wire logic [7:0] writeData,
	input wire logic [3:0] readAddr,
	output logic [7:0] readData
);
	// Ten configuration words plus the column parity word
	logic [7:0] cells [0:10];

	// Cleared store is self-consistent: all zero, parity zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i <= 10; i++) begin
				cells[i] <= 8'h00;
			end
		end else if (writeEnable && writeAddr <= 4'hA) begin
			cells[writeAddr] <= writeData;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readData <= 8'h00;
		end else if (readAddr <= 4'hA) begin
			readData <= cells[readAddr];
		end else begin
			readData <= 8'h00;
		end
	end
endmodule : cbnv_nvm_store
`default_nettype wire

// ### rtl/cbnv_top.sv
// Cell balancing, key-protected configuration store and open-cell check
`include "cbnv_defines.svh"
`default_nettype none
module cbnv_top #(
	parameter logic [63:0] HOUR_CYCLES = 64'(`CBNV_HOUR_S) * 64'(`CBNV_CLK_HZ),
	parameter logic [31:0] LOAD_CYCLES = 32'(`CBNV_LOAD_MS * (`CBNV_CLK_HZ / 1000)),
	parameter logic [31:0] PERIOD_CYCLES = 32'(`CBNV_PERIOD_S * `CBNV_CLK_HZ)
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic serialPortEnablePin,
	input wire logic serialClockLine,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOe,
	input wire logic commitStrobePin,
	input wire logic chargerDetectPin,
	input wire logic [7:0] cellAtThreshold,
	input wire logic [7:0] cellDiffBelowLimit,
	input wire logic protChargeOk,
	input wire logic protDischargeOk,
	output logic chargeFetDrive,
	output logic dischargeFetDrive,
	output logic [3:0] balanceThresholdCode,
	output logic balanceActive,
	output logic [7:0] balanceCells,
	output logic delayRangeLimited,
	output logic chargeShortExtendAllowed,
	output logic [7:0] openCellLoad,
	output logic [7:0] openCellFault,
	output logic parityFail,
	output logic [71:0] protectionConfig
);
	// Pin synchronisers: stage A is read only by stage B
	logic [20:0] syncA;
	logic [20:0] syncB;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncA <= 21'h00_0000;
			syncB <= 21'h00_0000;
		end else begin
			syncA <= {serialPortEnablePin, serialClockLine, serialDataIn, commitStrobePin,
				chargerDetectPin, cellAtThreshold, cellDiffBelowLimit};
			syncB <= syncA;
		end
	end
	logic portEn, scl, sda, strobe, charger;
	logic [7:0] cellHigh, cellLow;
	assign {portEn, scl, sda, strobe, charger, cellHigh, cellLow} = syncB;

	// Configuration registers 0x01-0x0A, key register 0x0B
	logic [7:0] shadow [0:9];
	logic [7:0] programKey;
	logic wrStrobe;
	logic [7:0] wrAddr, wrData;
	logic loadValid;
	logic [3:0] loadIdx;
	logic [7:0] nvReadData;

	// Serial slave, alive only with the port enable high
	cbnv_pkg::cbnv_i2c_state_t i2cState;
	logic sclQ, sdaQ, masterAck;
	logic [3:0] bitCnt;
	logic [7:0] shiftIn, outShift, pointer, readByte;
	wire sclRise = scl & ~sclQ;
	wire sclFall = ~scl & sclQ;
	wire busStart = scl & sclQ & sdaQ & ~sda;
	wire busStop = scl & sclQ & ~sdaQ & sda;

	always_comb begin
		if (pointer >= 8'h01 && pointer <= `CBNV_REG_BAL_CFG) begin
			readByte = shadow[4'(pointer - 8'h01)];
		end else if (pointer == `CBNV_REG_KEY) begin
			readByte = programKey;
		end else begin
			readByte = 8'h00;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			i2cState <= cbnv_pkg::I2C_IDLE;
			bitCnt <= 4'h0;
			shiftIn <= 8'h00;
			outShift <= 8'h00;
			pointer <= 8'h00;
			masterAck <= 1'b0;
			serialDataOe <= 1'b0;
			wrStrobe <= 1'b0;
			wrAddr <= 8'h00;
			wrData <= 8'h00;
		end else begin
			wrStrobe <= 1'b0;
			if (!portEn) begin
				i2cState <= cbnv_pkg::I2C_IDLE;
				serialDataOe <= 1'b0;
			end else if (busStart) begin
				i2cState <= cbnv_pkg::I2C_ADDR;
				// The start's own clock fall wraps this to zero
				bitCnt <= 4'hF;
				serialDataOe <= 1'b0;
			end else if (busStop) begin
				i2cState <= cbnv_pkg::I2C_IDLE;
				serialDataOe <= 1'b0;
			end else if (i2cState != cbnv_pkg::I2C_IDLE) begin
				if (sclRise && bitCnt < 4'h8) begin
					shiftIn <= {shiftIn[6:0], sda};
				end
				if (sclRise && bitCnt == 4'h8) begin
					masterAck <= ~sda;
				end
				if (sclFall) begin
					if (bitCnt == 4'h7) begin
						bitCnt <= 4'h8;
						case (i2cState)
							cbnv_pkg::I2C_ADDR: serialDataOe <= (shiftIn[7:1] == `CBNV_I2C_ADDR);
							cbnv_pkg::I2C_PTR: begin
								serialDataOe <= 1'b1;
								pointer <= shiftIn;
							end
							cbnv_pkg::I2C_WRITE: begin
								serialDataOe <= 1'b1;
								wrStrobe <= 1'b1;
								wrAddr <= pointer;
								wrData <= shiftIn;
								pointer <= pointer + 8'h01;
							end
							default: serialDataOe <= 1'b0;
						endcase
					end else if (bitCnt == 4'h8) begin
						bitCnt <= 4'h0;
						serialDataOe <= 1'b0;
						case (i2cState)
							cbnv_pkg::I2C_ADDR: begin
								if (shiftIn[7:1] != `CBNV_I2C_ADDR) begin
									i2cState <= cbnv_pkg::I2C_IDLE;
								end else if (shiftIn[0]) begin
									i2cState <= cbnv_pkg::I2C_READ;
									serialDataOe <= ~readByte[7];
									outShift <= {readByte[6:0], 1'b0};
									pointer <= pointer + 8'h01;
								end else begin
									i2cState <= cbnv_pkg::I2C_PTR;
								end
							end
							cbnv_pkg::I2C_PTR: i2cState <= cbnv_pkg::I2C_WRITE;
							cbnv_pkg::I2C_READ: begin
								if (masterAck) begin
									serialDataOe <= ~readByte[7];
									outShift <= {readByte[6:0], 1'b0};
									pointer <= pointer + 8'h01;
								end else begin
									i2cState <= cbnv_pkg::I2C_IDLE;
								end
							end
							default: i2cState <= i2cState;
						endcase
					end else begin
						bitCnt <= bitCnt + 4'h1;
						if (i2cState == cbnv_pkg::I2C_READ) begin
							serialDataOe <= ~outShift[7];
							outShift <= {outShift[6:0], 1'b0};
						end
					end
				end
			end
		end
	end

	// Open drain: the line is only ever pulled low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			serialDataOut <= 1'b0;
		end else begin
			serialDataOut <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 10; i++) begin
				shadow[i] <= 8'h00;
			end
		end else if (loadValid) begin
			shadow[loadIdx] <= nvReadData;
		end else if (wrStrobe && wrAddr >= 8'h01 && wrAddr <= `CBNV_REG_BAL_CFG) begin
			shadow[4'(wrAddr - 8'h01)] <= wrData;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			programKey <= `CBNV_KEY_RESET;
		end else if (wrStrobe && wrAddr == `CBNV_REG_KEY) begin
			programKey <= wrData;
		end
	end

	// Store sequencer: boot load, pre-read, commit, endless parity scan
	cbnv_pkg::cbnv_nv_mode_t nvMode, rdModeQ;
	logic [3:0] nvIndex, rdIndexQ;
	logic [7:0] commitAcc, scanAcc, nvWriteData;
	logic commitPend, prereadPend, strobeQ;
	wire strobeFall = strobeQ & ~strobe;
	wire commitReq = strobeFall && programKey == `CBNV_KEY_PROGRAM;
	wire prereadReq = wrStrobe && wrAddr == `CBNV_REG_KEY && wrData == `CBNV_KEY_PREREAD;
	wire nvWrite = nvMode == cbnv_pkg::NV_COMMIT;
	assign nvWriteData = (nvIndex == `CBNV_NV_LAST) ? commitAcc : shadow[nvIndex];
	assign loadValid = rdModeQ == cbnv_pkg::NV_LOAD && rdIndexQ < `CBNV_NV_LAST;
	assign loadIdx = rdIndexQ;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strobeQ <= 1'b0;
			nvMode <= cbnv_pkg::NV_LOAD;
			nvIndex <= 4'h0;
			commitAcc <= 8'h00;
			commitPend <= 1'b0;
			prereadPend <= 1'b0;
		end else begin
			strobeQ <= strobe;
			if (nvIndex == `CBNV_NV_LAST) begin
				nvIndex <= 4'h0;
				// Requests are consumed here; a preread waits behind a commit
				commitPend <= 1'b0;
				prereadPend <= (commitPend || commitReq) && (prereadPend || prereadReq);
				if (commitPend || commitReq) begin
					nvMode <= cbnv_pkg::NV_COMMIT;
				end else if (prereadPend || prereadReq) begin
					nvMode <= cbnv_pkg::NV_LOAD;
				end else begin
					nvMode <= cbnv_pkg::NV_SCAN;
				end
			end else begin
				nvIndex <= nvIndex + 4'h1;
				commitPend <= commitPend | commitReq;
				prereadPend <= prereadPend | prereadReq;
			end
			if (nvWrite) begin
				commitAcc <= (nvIndex == 4'h0) ? shadow[0] : commitAcc ^ nvWriteData;
			end
		end
	end

	cbnv_nvm_store store (
		.clk(clk),
		.reset(reset),
		.writeEnable(nvWrite),
		.writeAddr(nvIndex),
		.writeData(nvWriteData),
		.readAddr(nvIndex),
		.readData(nvReadData)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdModeQ <= cbnv_pkg::NV_SCAN;
			rdIndexQ <= 4'h0;
			scanAcc <= 8'h00;
			parityFail <= 1'b0;
		end else begin
			rdModeQ <= nvMode;
			rdIndexQ <= nvIndex;
			if (nvWrite && nvIndex == `CBNV_NV_LAST) begin
				parityFail <= 1'b0;
			end
			// Half-written words are never judged
			if (rdModeQ != cbnv_pkg::NV_COMMIT) begin
				if (rdIndexQ == 4'h0) begin
					scanAcc <= nvReadData;
				end else if (rdIndexQ < `CBNV_NV_LAST) begin
					scanAcc <= scanAcc ^ nvReadData;
				end else if (nvReadData != scanAcc) begin
					parityFail <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			chargeFetDrive <= 1'b0;
			dischargeFetDrive <= 1'b0;
			protectionConfig <= 72'h00_0000_0000_0000_0000;
		end else begin
			chargeFetDrive <= protChargeOk & ~parityFail;
			dischargeFetDrive <= protDischargeOk & ~parityFail;
			protectionConfig <= {shadow[8], shadow[7], shadow[6], shadow[5], shadow[4],
				shadow[3], shadow[2], shadow[1], shadow[0]};
		end
	end

	// Balance control
	wire [7:0] balCfg = shadow[9];
	wire [1:0] enSel = balCfg[`CBNV_EN_LSB +: 2];
	wire [1:0] toSel = balCfg[`CBNV_TO_LSB +: 2];
	cbnv_pkg::cbnv_bal_state_t balState;
	logic [42:0] balTimer;
	wire [63:0] limit64 = HOUR_CYCLES << toSel;
	wire timerDone = balTimer >= limit64[42:0] - 43'h1;
	wire anyHigh = |cellHigh;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			balState <= cbnv_pkg::BAL_IDLE;
		end else begin
			case (balState)
				cbnv_pkg::BAL_IDLE: begin
					if ((enSel == `CBNV_EN_ALWAYS && anyHigh)
						|| (enSel[1] && charger && anyHigh)) begin
						balState <= cbnv_pkg::BAL_RUN;
					end
				end
				cbnv_pkg::BAL_RUN: begin
					if (enSel == `CBNV_EN_OFF) begin
						balState <= cbnv_pkg::BAL_IDLE;
					end else if (enSel[1] && !charger) begin
						balState <= cbnv_pkg::BAL_IDLE;
					end else if (enSel != `CBNV_EN_CHARGER && timerDone) begin
						balState <= cbnv_pkg::BAL_DONE;
					end
				end
				cbnv_pkg::BAL_DONE: begin
					if (enSel == `CBNV_EN_OFF || enSel == `CBNV_EN_CHARGER) begin
						balState <= cbnv_pkg::BAL_IDLE;
					end else if (enSel == `CBNV_EN_ALWAYS && !anyHigh) begin
						balState <= cbnv_pkg::BAL_IDLE;
					end else if (enSel == `CBNV_EN_CHARGER_TIMED && !charger) begin
						balState <= cbnv_pkg::BAL_IDLE;
					end
				end
				default: balState <= cbnv_pkg::BAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			balTimer <= 43'h0;
		end else if (balState == cbnv_pkg::BAL_RUN) begin
			balTimer <= balTimer + 43'h1;
		end else begin
			balTimer <= 43'h0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			balanceActive <= 1'b0;
			balanceCells <= 8'h00;
			balanceThresholdCode <= 4'h0;
			delayRangeLimited <= 1'b0;
			chargeShortExtendAllowed <= 1'b0;
		end else begin
			balanceActive <= balState == cbnv_pkg::BAL_RUN;
			balanceCells <= (balState == cbnv_pkg::BAL_RUN) ? cellHigh : 8'h00;
			balanceThresholdCode <= balCfg[`CBNV_TH_LSB +: 4];
			delayRangeLimited <= enSel[1];
			chargeShortExtendAllowed <= balState == cbnv_pkg::BAL_RUN;
		end
	end

	// Open-cell check, one cell per period
	logic [31:0] periodCnt;
	logic [2:0] testIdx;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			periodCnt <= 32'h0000_0000;
			testIdx <= 3'h0;
			openCellLoad <= 8'h00;
			openCellFault <= 8'h00;
		end else begin
			periodCnt <= (periodCnt >= PERIOD_CYCLES - 32'h1) ? 32'h0 : periodCnt + 32'h1;
			if (periodCnt == 32'h0) begin
				openCellLoad <= 8'h01 << testIdx;
			end else if (periodCnt == LOAD_CYCLES) begin
				openCellLoad <= 8'h00;
				openCellFault[testIdx] <= cellLow[testIdx];
				testIdx <= testIdx + 3'h1;
			end
		end
	end
endmodule : cbnv_top
`default_nettype wire

// ### verif/cbnv_chk.sv
// Port checker for the cell-balance and configuration store block
`default_nettype none
module cbnv_chk #(
	parameter logic [31:0] LOAD_CYCLES = 32'hA,
	parameter logic [31:0] PERIOD_CYCLES = 32'h28
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic serialPortEnablePin,
	input wire logic serialDataOe,
	input wire logic protChargeOk,
	input wire logic protDischargeOk,
	input wire logic chargeFetDrive,
	input wire logic dischargeFetDrive,
	input wire logic balanceActive,
	input wire logic [7:0] balanceCells,
	input wire logic chargeShortExtendAllowed,
	input wire logic [7:0] openCellLoad,
	input wire logic parityFail
);
	logic [31:0] loadRun;
	logic [31:0] idleRun;
	logic [7:0] lastLoad;
	logic seenLoad;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Counters, since load runs exceed what a repetition may unroll
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			loadRun <= 32'h0;
			idleRun <= 32'h0;
		end else begin
			loadRun <= (|openCellLoad) ? loadRun + 32'h1 : 32'h0;
			idleRun <= (|openCellLoad) ? 32'h0 : idleRun + 32'h1;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lastLoad <= 8'h0;
			seenLoad <= 1'b0;
		end else if (|openCellLoad) begin
			lastLoad <= openCellLoad;
			seenLoad <= 1'b1;
		end
	end
	sequence s_port_off;
		!serialPortEnablePin [*5];
	endsequence
	sequence s_load_end;
		(|openCellLoad) ##1 !(|openCellLoad);
	endsequence
	sequence s_load_start;
		seenLoad && $rose(|openCellLoad);
	endsequence
	a_port_off_quiet: assert property (
		s_port_off |-> !serialDataOe)
		else $error("serial data driven while port disabled");
	a_parity_fets_off: assert property (
		parityFail |=> !chargeFetDrive && !dischargeFetDrive)
		else $error("FET drive on after parity failure");
	a_fets_follow_ok: assert property (
		!parityFail |=> chargeFetDrive == $past(protChargeOk)
			&& dischargeFetDrive == $past(protDischargeOk))
		else $error("FET drive does not follow protection request");
	a_short_extend_bal: assert property (
		chargeShortExtendAllowed == balanceActive)
		else $error("delay extension differs from balancing");
	a_cells_idle_off: assert property (
		!balanceActive && !$past(balanceActive) |-> balanceCells == 8'h0)
		else $error("cell bypass on while balancing idle");
	a_load_one_cell: assert property (
		$onehot0(openCellLoad))
		else $error("test load on more than one cell");
	a_load_length: assert property (
		s_load_end |-> loadRun == LOAD_CYCLES)
		else $error("test load length wrong");
	a_load_gap: assert property (
		s_load_start |-> idleRun == PERIOD_CYCLES - LOAD_CYCLES)
		else $error("test load spacing wrong");
	a_load_next_cell: assert property (
		s_load_start |-> openCellLoad == {lastLoad[6:0], lastLoad[7]})
		else $error("test load not on next cell");
endmodule : cbnv_chk
bind cbnv_top cbnv_chk #(.LOAD_CYCLES(LOAD_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)) i_cbnv_chk (
	.clk(clk), .reset(reset), .serialPortEnablePin(serialPortEnablePin),
	.serialDataOe(serialDataOe), .protChargeOk(protChargeOk), .protDischargeOk(protDischargeOk),
	.chargeFetDrive(chargeFetDrive), .dischargeFetDrive(dischargeFetDrive),
	.balanceActive(balanceActive), .balanceCells(balanceCells),
	.chargeShortExtendAllowed(chargeShortExtendAllowed), .openCellLoad(openCellLoad),
	.parityFail(parityFail));
`default_nettype wire

// ### verif/cbnv_i2c_host.sv
// Behavioural two-wire configuration host with pulled-up data line
`default_nettype none
module cbnv_i2c_host (
	input wire logic clk,
	input wire logic devicePullLow,
	output logic scl,
	output logic sdaLine
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hostFree;
	// Pull-up: a released line reads high
	assign sdaLine = hostFree & ~devicePullLow;
	initial begin
		scl = 1'b1;
		hostFree = 1'b1;
	end
	task automatic hold();
		repeat (6) @(negedge clk);
	endtask : hold
	task automatic start();
		hold();
		hostFree = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		hostFree = 1'b0;
		hold();
		scl = 1'b0;
	endtask : start
	task automatic stop();
		hold();
		hostFree = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		hostFree = 1'b1;
		hold();
	endtask : stop
	// Data moves only a hold after the clock fall, never beside it
	task automatic clockBit(input logic b, output logic r);
		hold();
		hostFree = b;
		hold();
		scl = 1'b1;
		hold();
		r = sdaLine;
		scl = 1'b0;
	endtask : clockBit
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic ninth);
		for (int i = 7; i >= 0; i--) clockBit(d[i], r[i]);
		clockBit(last, ninth);
	endtask : xfer
endmodule : cbnv_i2c_host
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench of the cell-balance and configuration store block
`include "cbnv_defines.svh"
`default_nettype none
`define CHK(got, e) begin compares++; if ((got) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h expected %h", $time, got, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] HOUR = 64'h40;
	logic clk, reset, portEnable, strobe, charger, chargeOk, dischargeOk, scl, sdaLine, sdaOe;
	logic chargeFet, dischargeFet, balActive, limited, pFail;
	logic [3:0] thCode;
	logic [7:0] cellAt, cellDiff, fault;
	logic [71:0] protCfg, expCfg;
	int errors, compares;
	cbnv_top #(.HOUR_CYCLES(HOUR), .LOAD_CYCLES(32'hA), .PERIOD_CYCLES(32'h28)) i_cbnv_top (
		.clk(clk), .reset(reset), .serialPortEnablePin(portEnable), .serialClockLine(scl),
		.serialDataIn(sdaLine), .serialDataOut(), .serialDataOe(sdaOe),
		.commitStrobePin(strobe), .chargerDetectPin(charger), .cellAtThreshold(cellAt),
		.cellDiffBelowLimit(cellDiff), .protChargeOk(chargeOk), .protDischargeOk(dischargeOk),
		.chargeFetDrive(chargeFet), .dischargeFetDrive(dischargeFet),
		.balanceThresholdCode(thCode),
		.balanceActive(balActive), .balanceCells(), .delayRangeLimited(limited),
		.chargeShortExtendAllowed(), .openCellLoad(), .openCellFault(fault),
		.parityFail(pFail), .protectionConfig(protCfg));
	cbnv_i2c_host host (.clk(clk), .devicePullLow(sdaOe), .scl(scl), .sdaLine(sdaLine));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test();
		if (errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask : ticks
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] nacks);
		logic [7:0] r;
		logic [2:0] k;
		host.start();
		host.xfer({`CBNV_I2C_ADDR, 1'b0}, 1'b1, r, k[2]);
		host.xfer(a, 1'b1, r, k[1]);
		host.xfer(d, 1'b1, r, k[0]);
		host.stop();
		`CHK(k, nacks)
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		logic k;
		host.start();
		host.xfer({`CBNV_I2C_ADDR, 1'b0}, 1'b1, r, k);
		host.xfer(a, 1'b1, r, k);
		host.start();
		host.xfer({`CBNV_I2C_ADDR, 1'b1}, 1'b1, r, k);
		host.xfer(8'hFF, 1'b1, r, k);
		host.stop();
		`CHK(r, e)
	endtask : rd
	task automatic pulse();
		strobe = 1'b1;
		ticks(4);
		strobe = 1'b0;
		ticks(30);
	endtask : pulse
	task automatic waitBal(input logic want, input int bound);
		for (int i = 0; i < bound && balActive !== want; i++) @(negedge clk);
		if (balActive !== want) begin
			errors++;
			$display("[ERR] %0t balancing wait ran out", $time);
			stop_test();
		end
	endtask : waitBal
	task automatic measure(input logic [63:0] want);
		int n;
		n = 0;
		waitBal(1'b1, 200);
		while (balActive === 1'b1 && n < 2000) begin
			n++;
			@(negedge clk);
		end
		`CHK(n >= want - 1 && n <= want + 1, 1'b1)
	endtask : measure
	initial begin
		errors = 0;
		compares = 0;
		reset = 1'b1;
		portEnable = 1'b1;
		strobe = 1'b0;
		charger = 1'b0;
		chargeOk = 1'b1;
		dischargeOk = 1'b0;
		cellAt = 8'h0;
		cellDiff = 8'h04;
		repeat (6) @(negedge clk);
		reset = 1'b0;
		ticks(16);
		rd(`CBNV_REG_KEY, `CBNV_KEY_RESET);
		rd(`CBNV_REG_BAL_CFG, 8'h00);
		rd(8'h0C, 8'h00);
		`CHK({chargeFet, dischargeFet}, 2'b10)
		chargeOk = 1'b0;
		dischargeOk = 1'b1;
		ticks(3);
		`CHK({chargeFet, dischargeFet}, 2'b01)
		cellAt = 8'h01;
		charger = 1'b1;
		ticks(40);
		`CHK({balActive, limited}, 2'b00)
		cellAt = 8'h00;
		charger = 1'b0;
		for (int i = 1; i < 10; i++) begin
			wr(8'(i), {4'(i), 4'hA}, 3'b000);
			expCfg[8 * i - 8 +: 8] = {4'(i), 4'hA};
		end
		wr(`CBNV_REG_KEY, `CBNV_KEY_PROGRAM, 3'b000);
		pulse();
		`CHK({pFail, protCfg}, {1'b0, expCfg})
		wr(8'h01, 8'h00, 3'b000);
		wr(`CBNV_REG_KEY, 8'h00, 3'b000);
		// Strobe without the key must leave the stored word alone
		pulse();
		wr(`CBNV_REG_KEY, `CBNV_KEY_PREREAD, 3'b000);
		ticks(30);
		rd(8'h01, 8'h1A);
		rd(`CBNV_REG_KEY, `CBNV_KEY_PREREAD);
		`CHK(protCfg, expCfg)
		portEnable = 1'b0;
		ticks(10);
		wr(`CBNV_REG_BAL_CFG, 8'h55, 3'b111);
		portEnable = 1'b1;
		ticks(10);
		rd(`CBNV_REG_BAL_CFG, 8'h00);
		for (int t = 0; t < 4; t++) begin
			wr(`CBNV_REG_BAL_CFG, {2'b01, 2'(t), 2'(t), 2'b11}, 3'b000);
			`CHK(thCode, {2'(t), 2'b11})
			cellAt = 8'h04;
			measure(HOUR << t);
			ticks(20);
			`CHK(balActive, 1'b0)
			cellAt = 8'h00;
			ticks(10);
		end
		wr(`CBNV_REG_BAL_CFG, 8'h80, 3'b000);
		cellAt = 8'h04;
		ticks(30);
		`CHK(balActive, 1'b0)
		charger = 1'b1;
		waitBal(1'b1, 50);
		ticks(600);
		`CHK({balActive, limited}, 2'b11)
		charger = 1'b0;
		waitBal(1'b0, 50);
		wr(`CBNV_REG_BAL_CFG, 8'hC0, 3'b000);
		cellAt = 8'h00;
		charger = 1'b1;
		ticks(100);
		cellAt = 8'h04;
		measure(HOUR);
		ticks(20);
		`CHK(balActive, 1'b0)
		charger = 1'b0;
		ticks(10);
		charger = 1'b1;
		waitBal(1'b1, 50);
		charger = 1'b0;
		waitBal(1'b0, 50);
		`CHK(fault, 8'h04)
		cellDiff = 8'h00;
		ticks(360);
		`CHK(fault, 8'h00)
		stop_test();
	end
endmodule : tb
`default_nettype wire
